// ===== src/mpc_pkg.sv
// Operation
// RQ1 - Overheat code 01/10/11 caps phase current at 1 A, 1.6 A, 2 A on warning.
// RQ2 - Overheat code 00 gives no thermal cap; only the acceleration cap applies.
// RQ3 - Bit 13 enables closed-loop stall detection without zero crossing.
// RQ4 - Bit 12 enables open-loop stall detection without zero crossing.
// RQ5 - Bit 11 enables the absent-motor fault.
// RQ6 - Bit 10 enables the abnormal torque-constant lock check.
// RQ7 - Bit 9 enables the abnormal-speed lock check.
// RQ8 - Bit 8 enables lock detection on reaching the stall current cap.
// RQ9 - Acceleration cap code 0000 means no acceleration current cap.
// RQ10 - Acceleration cap code n from 0001 to 1111 caps current at n times 0.2 A.
// RQ11 - Range one: field top bit ignored; 2.5, 1.9, 1.5, 0.9 A for codes 00-11.
// RQ12 - Range two: stall cap is 0.4 A at 000 up to 3.2 A at 111, 0.4 A steps.
// RQ13 - Protection bit 0 clear picks stall cap range one, set picks range two.
// RQ14 - Loop-control register sits at 0x95, resets to 0x00, all fields read/write.
// RQ15 - Loop bit 15 selects analog (0) or pulse-width (1) speed input.
// RQ16 - Loop bit 14 selects 25 kHz (0) or 50 kHz (1) output switching rate.
// RQ17 - Loop bit 7 clear moves to closed loop at threshold; set stays open loop.
// RQ18 - Loop bit 8 picks braking (0) or high impedance (1) after position probing.
// RQ19 - Host writes whole 16-bit words; new settings steer later current decisions.
package mpc_pkg;

   localparam logic [7:0]  ADDR_PROT  = 8'h94;
   localparam logic [7:0]  ADDR_LOOP  = 8'h95;
   localparam logic [15:0] PROT_RESET = 16'h0000;
   localparam logic [15:0] LOOP_RESET = 16'h0000;

   // Current figures are in units of 0.1 A.
   localparam logic [5:0] OT_CAP_1A0   = 6'h0A;
   localparam logic [5:0] OT_CAP_1A6   = 6'h10;
   localparam logic [5:0] OT_CAP_2A0   = 6'h14;
   localparam logic [5:0] STALL_R1_2A5 = 6'h19;
   localparam logic [5:0] STALL_R1_1A9 = 6'h13;
   localparam logic [5:0] STALL_R1_1A5 = 6'h0F;
   localparam logic [5:0] STALL_R1_0A9 = 6'h09;

   typedef struct packed {
      logic [1:0] overheatCurrentCap;
      logic       closedLoopStallDetectEn;
      logic       openLoopStallDetectEn;
      logic       absentMotorDetectEn;
      logic       torqueConstantCheckEn;
      logic       speedAnomalyDetectEn;
      logic       stallCurrentDetectEn;
      logic [3:0] accelCurrentCap;
      logic [2:0] stallCurrentCap;
      logic       stallCapRangeSel;
   } mpc_prot_t;

   typedef struct packed {
      logic       speedSourceSel;
      logic       outputSwitchingRateSel;
      logic [1:0] torqueConstantWindow;
      logic       inductiveSurgeGuardEn;
      logic       mechanicalSurgeGuardEn;
      logic       mechanicalSurgeGuardSel;
      logic       positionProbeReleaseSel;
      logic       stayOpenLoop;
      logic [2:0] closedLoopRamp;
      logic [1:0] minDutyPolicy;
      logic [1:0] phaseEdgeRate;
   } mpc_loop_t;

   typedef struct packed {
      logic [5:0] overheatCap;
      logic [5:0] accelCap;
      logic [5:0] stallCap;
   } mpc_caps_t;

endpackage

// ===== src/mpc_limit_decode.sv
`timescale 1ns/1ps
module mpc_limit_decode (
   input  mpc_pkg::mpc_prot_t prot,
   output mpc_pkg::mpc_caps_t caps
);
   logic [3:0] stepCount;

   always_comb begin
      stepCount = {1'b0, prot.stallCurrentCap} + 4'h1;
      case (prot.overheatCurrentCap)
         2'b01:   caps.overheatCap = mpc_pkg::OT_CAP_1A0; // RQ1
         2'b10:   caps.overheatCap = mpc_pkg::OT_CAP_1A6; // RQ1
         2'b11:   caps.overheatCap = mpc_pkg::OT_CAP_2A0; // RQ1
         default: caps.overheatCap = 6'h00;
      endcase
      caps.accelCap = {1'b0, prot.accelCurrentCap, 1'b0}; // RQ10
      if (prot.stallCapRangeSel) begin // RQ13
         caps.stallCap = {stepCount, 2'b00}; // RQ12
      end else begin
         // The top field bit plays no part in range one.
         case (prot.stallCurrentCap[1:0]) // RQ11
            2'b00:   caps.stallCap = mpc_pkg::STALL_R1_2A5;
            2'b01:   caps.stallCap = mpc_pkg::STALL_R1_1A9;
            2'b10:   caps.stallCap = mpc_pkg::STALL_R1_1A5;
            default: caps.stallCap = mpc_pkg::STALL_R1_0A9;
         endcase
      end
   end
endmodule // mpc_limit_decode

// ===== src/mpc_config_regs.sv
`timescale 1ns/1ps
module mpc_config_regs (
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  regAddr,
   input  wire logic [15:0] regWrData,
   input  wire logic        regWrEn,
   input  wire logic        regRdEn,
   output logic [15:0]      regRdData,
   output logic             regRdValid,
   input  wire logic        overTempWarn,
   input  wire logic        closedLoopStallSeen,
   input  wire logic        openLoopStallSeen,
   input  wire logic        motorAbsentSeen,
   input  wire logic        torqueAbnormalSeen,
   input  wire logic        speedAbnormalSeen,
   input  wire logic [5:0]  phaseCurrent,
   output logic [5:0]       currentCap,
   output logic             currentCapEn,
   output logic [5:0]       stallCap,
   output logic [5:0]       lockCauses,
   output logic             lockFault,
   output mpc_pkg::mpc_loop_t loopConfig
);
   mpc_pkg::mpc_prot_t protReg_r;
   mpc_pkg::mpc_loop_t loopReg_r;
   mpc_pkg::mpc_caps_t caps;
   logic [15:0]        regRdData_r;
   logic               regRdValid_r;
   logic [5:0]         currentCap_r;
   logic               currentCapEn_r;
   logic [5:0]         stallCap_r;
   logic [5:0]         lockCauses_r;
   logic               lockFault_r;
   logic [5:0]         lockCauses_nxt;
   logic               overheatCapActive;

   mpc_limit_decode mpc_limit_decode_inst (
      .prot (protReg_r),
      .caps (caps)
   );

   // Each write replaces the whole 16-bit word, so no partial update is kept.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         protReg_r <= mpc_pkg::PROT_RESET;
      end else if (regWrEn && regAddr == mpc_pkg::ADDR_PROT) begin
         protReg_r <= regWrData; // RQ19
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         loopReg_r <= mpc_pkg::LOOP_RESET; // RQ14
      end else if (regWrEn && regAddr == mpc_pkg::ADDR_LOOP) begin
         loopReg_r <= regWrData; // RQ14
      end
   end

   // Unmapped addresses read as zero; a read answers one cycle later.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         regRdData_r  <= 16'h0000;
         regRdValid_r <= 1'b0;
      end else begin
         regRdValid_r <= regRdEn;
         if (regRdEn) begin
            case (regAddr)
               mpc_pkg::ADDR_PROT: regRdData_r <= protReg_r;
               mpc_pkg::ADDR_LOOP: regRdData_r <= loopReg_r; // RQ14
               default:            regRdData_r <= 16'h0000;
            endcase
         end
      end
   end

   assign overheatCapActive = overTempWarn && (protReg_r.overheatCurrentCap != 2'b00);

   // The thermal cap replaces the acceleration cap one cycle after the warning rises with a code other than 00, until one cycle after it falls.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         currentCap_r   <= 6'h00;
         currentCapEn_r <= 1'b0;
      end else if (overheatCapActive) begin
         currentCap_r   <= caps.overheatCap; // RQ1
         currentCapEn_r <= 1'b1; // RQ1
      end else begin
         currentCap_r   <= caps.accelCap; // RQ2
         currentCapEn_r <= (protReg_r.accelCurrentCap != 4'h0); // RQ9
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stallCap_r <= 6'h00;
      end else begin
         stallCap_r <= caps.stallCap; // RQ13
      end
   end

   // The stall comparison uses the registered cap, so a new setting bites one cycle late.
   always_comb begin
      lockCauses_nxt[5] = protReg_r.closedLoopStallDetectEn && closedLoopStallSeen; // RQ3
      lockCauses_nxt[4] = protReg_r.openLoopStallDetectEn && openLoopStallSeen; // RQ4
      lockCauses_nxt[3] = protReg_r.absentMotorDetectEn && motorAbsentSeen; // RQ5
      lockCauses_nxt[2] = protReg_r.torqueConstantCheckEn && torqueAbnormalSeen; // RQ6
      lockCauses_nxt[1] = protReg_r.speedAnomalyDetectEn && speedAbnormalSeen; // RQ7
      lockCauses_nxt[0] = protReg_r.stallCurrentDetectEn && (phaseCurrent >= stallCap_r); // RQ8
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lockCauses_r <= 6'h00;
         lockFault_r  <= 1'b0;
      end else begin
         lockCauses_r <= lockCauses_nxt;
         lockFault_r  <= |lockCauses_nxt;
      end
   end

   assign regRdData    = regRdData_r;
   assign regRdValid   = regRdValid_r;
   assign currentCap   = currentCap_r;
   assign currentCapEn = currentCapEn_r;
   assign stallCap     = stallCap_r;
   assign lockCauses   = lockCauses_r;
   assign lockFault    = lockFault_r;
   // Loop-control fields leave straight from their flip-flops.
   assign loopConfig   = loopReg_r; // RQ15 RQ16 RQ17 RQ18

   property p_ot_cap_1a6; // RQ1
      @(posedge core_clk) disable iff (sys_rst)
         (overTempWarn && protReg_r.overheatCurrentCap == 2'b10) |=> (currentCapEn && currentCap == 6'h10);
   endproperty
   a_ot_cap_1a6: assert property (p_ot_cap_1a6) else $error("thermal cap not 1.6 A"); // RQ1

   property p_no_thermal_cap; // RQ2
      @(posedge core_clk) disable iff (sys_rst)
         (protReg_r.overheatCurrentCap == 2'b00)
         |=> (currentCap == {1'b0, $past(protReg_r.accelCurrentCap), 1'b0});
   endproperty
   a_no_thermal_cap: assert property (p_no_thermal_cap) else $error("thermal cap applied at code 00"); // RQ2

   property p_closed_stall_off; // RQ3
      @(posedge core_clk) disable iff (sys_rst)
         !protReg_r.closedLoopStallDetectEn |=> !lockCauses[5];
   endproperty
   a_closed_stall_off: assert property (p_closed_stall_off) else $error("closed-loop stall while off"); // RQ3

   property p_open_stall_on; // RQ4
      @(posedge core_clk) disable iff (sys_rst)
         (protReg_r.openLoopStallDetectEn && openLoopStallSeen) |=> (lockCauses[4] && lockFault);
   endproperty
   a_open_stall_on: assert property (p_open_stall_on) else $error("open-loop stall missed"); // RQ4

   property p_absent_motor_off; // RQ5
      @(posedge core_clk) disable iff (sys_rst)
         !protReg_r.absentMotorDetectEn |=> !lockCauses[3];
   endproperty
   a_absent_motor_off: assert property (p_absent_motor_off) else $error("absent motor fault while off"); // RQ5

   property p_stall_current; // RQ8
      @(posedge core_clk) disable iff (sys_rst)
         (protReg_r.stallCurrentDetectEn && phaseCurrent >= stallCap) |=> lockFault;
   endproperty
   a_stall_current: assert property (p_stall_current) else $error("stall current lock missed"); // RQ8

   property p_no_accel_cap; // RQ9
      @(posedge core_clk) disable iff (sys_rst)
         (!overheatCapActive && protReg_r.accelCurrentCap == 4'h0) |=> !currentCapEn;
   endproperty
   a_no_accel_cap: assert property (p_no_accel_cap) else $error("acceleration cap at code 0000"); // RQ9

   property p_range_one; // RQ11
      @(posedge core_clk) disable iff (sys_rst)
         (!protReg_r.stallCapRangeSel && protReg_r.stallCurrentCap[1:0] == 2'b01) |=> (stallCap == 6'h13);
   endproperty
   a_range_one: assert property (p_range_one) else $error("range one code 01 not 1.9 A"); // RQ11

   property p_range_two; // RQ12
      @(posedge core_clk) disable iff (sys_rst)
         (protReg_r.stallCapRangeSel && protReg_r.stallCurrentCap == 3'b111) |=> (stallCap == 6'h20);
   endproperty
   a_range_two: assert property (p_range_two) else $error("range two code 111 not 3.2 A"); // RQ12

   property p_loop_readback; // RQ14
      @(posedge core_clk) disable iff (sys_rst)
         (regWrEn && regAddr == 8'h95) ##1 (regRdEn && !regWrEn && regAddr == 8'h95)
         |=> (regRdValid && regRdData == $past(regWrData, 2));
   endproperty
   a_loop_readback: assert property (p_loop_readback) else $error("loop register readback mismatch"); // RQ14

   property p_speed_source; // RQ15
      @(posedge core_clk) disable iff (sys_rst)
         (regWrEn && regAddr == 8'h95) |=> (loopConfig.speedSourceSel == $past(regWrData[15])
                                            && loopConfig.stayOpenLoop == $past(regWrData[7]));
   endproperty
   a_speed_source: assert property (p_speed_source) else $error("loop fields not updated"); // RQ15

   property p_ot_cap_2a0; // RQ1
      @(posedge core_clk) disable iff (sys_rst)
         (overTempWarn && protReg_r.overheatCurrentCap == 2'b11) |=> (currentCapEn && currentCap == 6'h14);
   endproperty
   a_ot_cap_2a0: assert property (p_ot_cap_2a0) else $error("thermal cap not 2 A"); // RQ1

   property p_torque_check_off; // RQ6
      @(posedge core_clk) disable iff (sys_rst)
         !protReg_r.torqueConstantCheckEn |=> !lockCauses[2];
   endproperty
   a_torque_check_off: assert property (p_torque_check_off) else $error("torque lock while off"); // RQ6

   property p_speed_check_on; // RQ7
      @(posedge core_clk) disable iff (sys_rst)
         (protReg_r.speedAnomalyDetectEn && speedAbnormalSeen) |=> (lockCauses[1] && lockFault);
   endproperty
   a_speed_check_on: assert property (p_speed_check_on) else $error("speed lock missed"); // RQ7

   property p_accel_cap; // RQ10
      @(posedge core_clk) disable iff (sys_rst)
         (!overheatCapActive && protReg_r.accelCurrentCap != 4'h0)
         |=> (currentCapEn && currentCap == {1'b0, $past(protReg_r.accelCurrentCap), 1'b0});
   endproperty
   a_accel_cap: assert property (p_accel_cap) else $error("acceleration cap not n times 0.2 A"); // RQ10

   // Range one must drop the top field bit, so code 111 has to read as 0.9 A.
   property p_range_sel; // RQ13
      @(posedge core_clk) disable iff (sys_rst)
         (!protReg_r.stallCapRangeSel && protReg_r.stallCurrentCap == 3'b111) |=> (stallCap == 6'h09);
   endproperty
   a_range_sel: assert property (p_range_sel) else $error("range one used the top field bit"); // RQ13

   property p_loop_rate; // RQ16
      @(posedge core_clk) disable iff (sys_rst)
         (regWrEn && regAddr == mpc_pkg::ADDR_LOOP)
         |=> (loopConfig.outputSwitchingRateSel == $past(regWrData[14])
              && loopConfig.positionProbeReleaseSel == $past(regWrData[8]));
   endproperty
   a_loop_rate: assert property (p_loop_rate) else $error("rate or release field not updated"); // RQ16
endmodule // mpc_config_regs

// ===== sim/mpc_host_model.sv
`timescale 1ns/1ps
module mpc_host_model (
   input  wire logic        core_clk,
   output logic [7:0]       regAddr,
   output logic [15:0]      regWrData,
   output logic             regWrEn,
   output logic             regRdEn,
   input  wire logic [15:0] regRdData,
   input  wire logic        regRdValid
);
   initial begin
      regAddr = 8'h00;
      regWrData = 16'h0000;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
   end

   // The word is inverted after the strobe so a stale bus value can never pass for a write.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge core_clk);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge core_clk);
      regWrEn = 1'b0;
      regWrData = ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
      @(negedge core_clk);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge core_clk);
      v = regRdValid;
      d = regRdData;
      regRdEn = 1'b0;
   endtask

   // Write and read back in the very next cycle, the tightest order the port accepts.
   task automatic wrrd(input logic [7:0] a, input logic [15:0] wd, output logic [15:0] d, output logic v);
      @(negedge core_clk);
      regAddr = a;
      regWrData = wd;
      regWrEn = 1'b1;
      @(negedge core_clk);
      regWrEn = 1'b0;
      regWrData = ~wd;
      regRdEn = 1'b1;
      @(negedge core_clk);
      v = regRdValid;
      d = regRdData;
      regRdEn = 1'b0;
   endtask
endmodule // mpc_host_model

// ===== sim/mpc_config_regs_test.sv
`timescale 1ns/1ps
module mpc_config_regs_test;
   logic               core_clk;
   logic               sys_rst;
   logic [7:0]         regAddr;
   logic [15:0]        regWrData;
   logic               regWrEn;
   logic               regRdEn;
   logic [15:0]        regRdData;
   logic               regRdValid;
   logic               overTempWarn;
   logic [4:0]         seen;
   logic [5:0]         phaseCurrent;
   logic [5:0]         currentCap;
   logic               currentCapEn;
   logic [5:0]         stallCap;
   logic [5:0]         lockCauses;
   logic               lockFault;
   mpc_pkg::mpc_loop_t loopConfig;
   logic [15:0]        d;
   logic               v;
   int                 fail_count = 0;
   int                 num_checks = 0;
   int                 cycles = 0;

   mpc_config_regs mpc_config_regs_inst (.core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
      .regRdValid(regRdValid), .overTempWarn(overTempWarn), .closedLoopStallSeen(seen[4]),
      .openLoopStallSeen(seen[3]), .motorAbsentSeen(seen[2]), .torqueAbnormalSeen(seen[1]),
      .speedAbnormalSeen(seen[0]), .phaseCurrent(phaseCurrent), .currentCap(currentCap),
      .currentCapEn(currentCapEn), .stallCap(stallCap), .lockCauses(lockCauses), .lockFault(lockFault),
      .loopConfig(loopConfig));
   mpc_host_model mpc_host_model_inst (.core_clk(core_clk), .regAddr(regAddr), .regWrData(regWrData),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic print_verdict;
      if (fail_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic put_prot(input logic [15:0] w);
      mpc_host_model_inst.wr(8'h94, w);
      repeat (2) @(negedge core_clk);
   endtask

   task automatic test_reset_and_loop;
      mpc_host_model_inst.rd(8'h94, d, v);
      chk({15'h0000, v}, 16'h0001);
      chk(d, 16'h0000);
      mpc_host_model_inst.rd(8'h95, d, v);
      chk({15'h0000, v}, 16'h0001);
      chk(d, 16'h0000);
      chk({10'h000, stallCap}, 16'h0019);
      mpc_host_model_inst.wr(8'h95, 16'hC180);
      chk(loopConfig, 16'hC180);
      mpc_host_model_inst.rd(8'h95, d, v);
      chk({15'h0000, v}, 16'h0001);
      chk(d, 16'hC180);
      mpc_host_model_inst.rd(8'h96, d, v);
      chk(d, 16'h0000);
      mpc_host_model_inst.wrrd(8'h95, 16'h2A5C, d, v);
      chk({15'h0000, v}, 16'h0001);
      chk(d, 16'h2A5C);
      chk(loopConfig, 16'h2A5C);
   endtask

   task automatic test_caps;
      // Code 00 leaves the 0.6 A acceleration cap in charge, so it differs from every thermal figure.
      logic [5:0] ot[4] = '{6'h06, 6'h0A, 6'h10, 6'h14};
      overTempWarn = 1'b1;
      for (int c = 0; c < 4; c++) begin
         put_prot({c[1:0], 6'h00, 4'h3, 4'h0});
         chk({9'h000, currentCapEn, currentCap}, {9'h000, 1'b1, ot[c]});
      end
      overTempWarn = 1'b0;
      for (int n = 0; n < 16; n++) begin
         put_prot({2'h3, 6'h00, n[3:0], 4'h0});
         chk({9'h000, currentCapEn, currentCap}, {9'h000, n != 0, 6'(2 * n)});
      end
   endtask

   task automatic test_stall;
      logic [5:0] r1[4] = '{6'h19, 6'h13, 6'h0F, 6'h09};
      for (int r = 0; r < 2; r++) begin
         for (int c = 0; c < 8; c++) begin
            put_prot({12'h000, c[2:0], r[0]});
            chk({10'h000, stallCap}, r == 1 ? 16'(4 * (c + 1)) : {10'h000, r1[c % 4]});
         end
      end
   endtask

   task automatic test_lock;
      seen = 5'h1F;
      phaseCurrent = 6'h3F;
      put_prot(16'h0000);
      chk({9'h000, lockFault, lockCauses}, 16'h0000);
      for (int b = 0; b < 6; b++) begin
         put_prot(16'h0100 << b);
         chk({9'h000, lockFault, lockCauses}, 16'h0040 | (16'h0001 << b));
      end
      // A single condition shows that the closed-loop stall input sets cause 5 alone.
      seen = 5'h10;
      phaseCurrent = 6'h00;
      put_prot(16'h3F00);
      chk({9'h000, lockFault, lockCauses}, 16'h0060);
      seen = 5'h00;
      put_prot(16'h3F00);
      chk({9'h000, lockFault, lockCauses}, 16'h0000);
   endtask

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         print_verdict();
      end
   end

   initial begin
      sys_rst = 1'b1;
      overTempWarn = 1'b0;
      seen = 5'h00;
      phaseCurrent = 6'h00;
      repeat (8) @(negedge core_clk);
      sys_rst = 1'b0;
      @(negedge core_clk);
      test_reset_and_loop();
      test_caps();
      test_stall();
      test_lock();
      print_verdict();
   end
endmodule // mpc_config_regs_test
